//--- hdl/plc_fabric.sv
// configurable logic fabric: shared and-or array, logic cells, io and input cells
// assumes all *_cfg inputs are static and pins are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module plc_fabric
    import plc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clock_pin_one,
    input wire logic clock_pin_two,
    input wire logic [IN_N-1:0] in_pin,
    input wire logic [IO_N-1:0] io_in,
    output logic [IO_N-1:0] io_out,
    output logic [IO_N-1:0] io_oe_n,
    input wire logic [PT_N-1:0][ARR_N-1:0] and_t_cfg,
    input wire logic [PT_N-1:0][ARR_N-1:0] and_c_cfg,
    input wire logic [SUM_N-1:0][PT_N-1:0] or_cfg,
    input wire plc_gck_t gck_sel_cfg [2],
    input wire logic [1:0] gio_pol_cfg,
    input wire plc_rtype_t rtype_cfg [LCC_N],
    input wire logic [LCC_N-1:0] dyn_type_cfg,
    input wire plc_bsel_t bsel_cfg [LCC_N],
    input wire plc_csel_t csel_cfg [LCC_N],
    input wire plc_dsel_t dsel_cfg [LCC_N],
    input wire plc_cksrc_t cksrc_cfg [LCC_N],
    input wire logic [LCC_N-1:0] ck_pol_cfg,
    input wire logic [LCC_N-1:0] async_cfg,
    input wire plc_osel_t osel_pin_cfg [LCC_N],
    input wire plc_osel_t osel_bur_cfg [LCC_N],
    input wire plc_inmode_t inc_mode_cfg [IN_N],
    input wire plc_inmode_t ioc_mode_cfg [IO_N],
    input wire logic [3:0] io_src_cfg [IO_N],
    input wire logic [IO_N-1:0] io_pol_cfg,
    input wire plc_oe_t io_oe_cfg [IO_N]
);

    // ------------------------------------------------------------
    // reset release and pin stage state
    // ------------------------------------------------------------
    plc_top_st_t st_q;
    plc_top_st_t st_d;
    logic rst_n;
    logic [ARR_N-1:0] arr;
    logic [PT_N-1:0] pt;
    logic [SUM_N-1:0] sum;
    logic [1:0] g_clk;
    logic [1:0] g_io_ck;
    logic [IN_N-1:0] inc_val;
    logic [IO_N-1:0] ioc_val;
    logic [LCC_N-1:0] lcc_pin;
    logic [LCC_N-1:0] lcc_bur;
    logic [LCC_N-1:0] lcc_oe;
    logic [LCC_N-1:0] lcc_fb;
    logic [LCC_N-1:0] cell_gclr;
    logic [IO_N-1:0] pin_val;
    logic [IO_N-1:0] oe_val;

    assign rst_n = st_q.sync[1];

    // pins only start driving once the released reset has passed both stages
    always_comb
    begin
        st_d = st_q;
        st_d.sync = {st_q.sync[0], 1'h1};
        if (!rst_n)
        begin
            st_d.out = {IO_N{RST_OUT}};
            st_d.oe_n = {IO_N{RST_OE_N}};
        end
        else
        begin
            st_d.out = pin_val;
            st_d.oe_n = ~oe_val;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_q <= '{sync: 2'h0, out: {IO_N{RST_OUT}}, oe_n: {IO_N{RST_OE_N}}};
        else
            st_q <= st_d;
    end

    assign io_out = st_q.out;
    assign io_oe_n = st_q.oe_n;

    // ------------------------------------------------------------
    // and-or array
    // ------------------------------------------------------------
    // array inputs: input cells, io cells, buried outputs, sum d feedback, clock pins
    always_comb
    begin
        arr = '0;
        arr[ARR_INC +: IN_N] = inc_val;
        arr[ARR_IOC +: IO_N] = ioc_val;
        arr[ARR_BUR +: LCC_N] = lcc_bur;
        arr[ARR_FBD +: LCC_N] = lcc_fb;
        arr[ARR_CK1] = clock_pin_one;
        arr[ARR_CK2] = clock_pin_two;
    end

    // a term with no literal connected reads as one
    for (genvar p = 0; p < PT_N; p++)
    begin : g_pt
        assign pt[p] = &((~and_t_cfg[p] | arr) & (~and_c_cfg[p] | ~arr));
    end

    // each sum or's its own copy of the term vector, so sharing costs nothing
    for (genvar s = 0; s < SUM_N; s++)
    begin : g_sum
        if (s < GSUM_RST)
        begin : g_cell
            assign sum[s] = |(or_cfg[s][PT_LCC_N-1:0] & pt[PT_LCC_N-1:0]);
        end
        else
        begin : g_glob
            assign sum[s] = |(or_cfg[s] & pt);
        end
    end

    // ------------------------------------------------------------
    // global cells
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++)
    begin : g_gcell
        always_comb
        begin
            case (gck_sel_cfg[g])
                GK_PIN2: g_clk[g] = clock_pin_two;
                GK_PTERM: g_clk[g] = pt[PT_PCLK+g];
                default: g_clk[g] = clock_pin_one;
            endcase
        end
        assign g_io_ck[g] = g_clk[g] ^ gio_pol_cfg[g];
    end

    // ------------------------------------------------------------
    // input cells and io cells
    // ------------------------------------------------------------
    for (genvar i = 0; i < IO_N; i++)
    begin : g_io
        localparam int G = (i < GRP_SIZE) ? 0 : 1;

        plc_incell u_inc (
            .clk(clk),
            .rst_n(rst_n),
            .pin(in_pin[i]),
            .ck(g_io_ck[G]),
            .mode(inc_mode_cfg[i]),
            .value(inc_val[i])
        );

        plc_incell u_ioc (
            .clk(clk),
            .rst_n(rst_n),
            .pin(io_in[i]),
            .ck(g_io_ck[G]),
            .mode(ioc_mode_cfg[i]),
            .value(ioc_val[i])
        );

        // any logic cell can feed the pin; the enable is fixed on, fixed off, or taken from sum d of cell i
        always_comb
        begin
            pin_val[i] = io_pol_cfg[i];
            if (io_src_cfg[i] < 4'(LCC_N))
                pin_val[i] = lcc_pin[io_src_cfg[i]] ^ io_pol_cfg[i];
            case (io_oe_cfg[i])
                OE_ON: oe_val[i] = 1'h1;
                OE_SUMD: oe_val[i] = lcc_oe[i];
                default: oe_val[i] = 1'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // logic control cells
    // ------------------------------------------------------------
    for (genvar i = 0; i < LCC_N; i++)
    begin : g_lcc
        localparam int G = (i < GRP_SIZE) ? 0 : 1;
        localparam int S = i * SUM_PER_LCC;

        assign cell_gclr[i] = sum[GSUM_RST+G];

        plc_lcc u_lcc (
            .clk(clk),
            .rst_n(rst_n),
            .sum_a(sum[S]),
            .sum_b(sum[S+1]),
            .sum_c(sum[S+2]),
            .sum_d(sum[S+3]),
            .g_clk(g_clk[G]),
            .g_preset(pt[PT_PRESET+G]),
            .g_reset(cell_gclr[i]),
            .g_rtype(pt[PT_RTYPE+G]),
            .rtype(rtype_cfg[i]),
            .dyn_type(dyn_type_cfg[i]),
            .bsel(bsel_cfg[i]),
            .csel(csel_cfg[i]),
            .dsel(dsel_cfg[i]),
            .cksrc(cksrc_cfg[i]),
            .ck_pol(ck_pol_cfg[i]),
            .async_ctl(async_cfg[i]),
            .osel_pin(osel_pin_cfg[i]),
            .osel_bur(osel_bur_cfg[i]),
            .out_pin(lcc_pin[i]),
            .out_bur(lcc_bur[i]),
            .out_oe(lcc_oe[i]),
            .out_fb(lcc_fb[i])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    pin_drive_a: assert property ((io_oe_cfg[0] == OE_ON && io_src_cfg[0] == 4'h0)
        |=> io_out[0] == $past(lcc_pin[0] ^ io_pol_cfg[0]) && !io_oe_n[0])
        else $error("io pin does not follow its logic cell");
    oe_sumd_a: assert property ((io_oe_cfg[7] == OE_SUMD) |=> io_oe_n[7] == !$past(lcc_oe[7]))
        else $error("io enable does not follow sum d");
    sumd_feedback_a: assert property ((dsel_cfg[0] == D_FEEDBACK) |-> arr[ARR_FBD] == sum[3])
        else $error("sum d not fed back to array");
    gclk_select_a: assert property ((gck_sel_cfg[1] == GK_PIN2) |-> g_clk[1] == clock_pin_two)
        else $error("global clock select wrong");
    group_split_a: assert property (cell_gclr[GRP_SIZE] == sum[GSUM_RST+1] && cell_gclr[0] == sum[GSUM_RST])
        else $error("cell group uses wrong global cell");
    empty_term_a: assert property ((and_t_cfg[2] == '0 && and_c_cfg[2] == '0) |-> pt[2])
        else $error("unconnected product term not true");
    reserved_terms_a: assert property ((or_cfg[24][PT_LCC_N-1:0] == '0) |-> !sum[24])
        else $error("reserved product term reached a cell sum");
    term_share_a: assert property ((or_cfg[0][0] && or_cfg[4][0] && pt[0]) |-> sum[0] && sum[4])
        else $error("shared product term not seen by both sums");
    io_drive_c: cover property (!io_oe_n[0] ##1 io_out[0] ##1 !io_out[0]);
    fb_use_c: cover property (dsel_cfg[0] == D_FEEDBACK && lcc_fb[0]);

endmodule
`default_nettype wire

//--- hdl/plc_pkg.sv
// constants, enumerations and state types shared by the logic cell fabric
// assumes one 50 MHz clock; all configuration inputs are held static while running
package plc_pkg;

    // ------------------------------------------------------------
    // array dimensions
    // ------------------------------------------------------------
    localparam int PT_N = 64;
    localparam int SUM_N = 50;
    localparam int LCC_N = 12;
    localparam int IN_N = 12;
    localparam int IO_N = 12;
    localparam int ARR_N = 50;
    localparam int GRP_SIZE = 6;
    localparam int SUM_PER_LCC = 4;

    // ------------------------------------------------------------
    // array input positions, global sums and reserved terms
    // ------------------------------------------------------------
    localparam int ARR_INC = 0;
    localparam int ARR_IOC = 12;
    localparam int ARR_BUR = 24;
    localparam int ARR_FBD = 36;
    localparam int ARR_CK1 = 48;
    localparam int ARR_CK2 = 49;
    localparam int GSUM_RST = 48;
    localparam int PT_LCC_N = 56;
    localparam int PT_PCLK = 56;
    localparam int PT_PRESET = 58;
    localparam int PT_RTYPE = 60;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_Q = 1'h0;
    localparam logic RST_OUT = 1'h0;
    localparam logic RST_OE_N = 1'h1;

    typedef enum logic [1:0] {RT_D, RT_T, RT_JK} plc_rtype_t;
    typedef enum logic [1:0] {B_K, B_PRESET, B_COMB} plc_bsel_t;
    typedef enum logic [1:0] {C_CLOCK, C_RESET, C_COMB} plc_csel_t;
    typedef enum logic [1:0] {D_CLOCK, D_OE, D_FEEDBACK} plc_dsel_t;
    typedef enum logic [1:0] {O_Q, O_SUMA, O_SUMB, O_SUMC} plc_osel_t;
    typedef enum logic [1:0] {CK_GLOBAL, CK_SUMC, CK_SUMD} plc_cksrc_t;
    typedef enum logic [1:0] {GK_PIN1, GK_PIN2, GK_PTERM} plc_gck_t;
    typedef enum logic [1:0] {IN_BYPASS, IN_REG, IN_LATCH} plc_inmode_t;
    typedef enum logic [1:0] {OE_OFF, OE_ON, OE_SUMD} plc_oe_t;

    typedef struct packed {
        logic q;
        logic ck_prev;
    } plc_lcc_st_t;

    typedef struct packed {
        logic held;
        logic ck_prev;
    } plc_inc_st_t;

    typedef struct packed {
        logic [1:0] sync;
        logic [IO_N-1:0] out;
        logic [IO_N-1:0] oe_n;
    } plc_top_st_t;

endpackage

//--- hdl/plc_incell.sv
// input storage cell: register, transparent latch or bypass
// assumes ck is the polarity-resolved clock level from the global cell
`timescale 1ns/1ps
`default_nettype none
module plc_incell
    import plc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic ck,
    input wire plc_inmode_t mode,
    output logic value
);

    plc_inc_st_t st_q;
    plc_inc_st_t st_d;

    // the cell clock is a sampled level, so edges are found against its last sample
    always_comb
    begin
        st_d = st_q;
        st_d.ck_prev = ck;
        if (mode == IN_REG && ck && !st_q.ck_prev)
            st_d.held = pin;
        else if (mode == IN_LATCH && ck)
            st_d.held = pin;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '{held: RST_Q, ck_prev: RST_Q};
        else
            st_q <= st_d;
    end

    // latch is see-through while clock is high
    always_comb
    begin
        case (mode)
            IN_BYPASS: value = pin;
            IN_REG: value = st_q.held;
            IN_LATCH: value = ck ? pin : st_q.held;
            default: value = pin;
        endcase
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    reg_capture_a: assert property ((mode == IN_REG && ck && !st_q.ck_prev) |=> value == $past(pin))
        else $error("input register missed rising edge");
    latch_hold_a: assert property ((mode == IN_LATCH && $fell(ck)) |-> value == $past(pin))
        else $error("latch did not hold value at falling edge");
    bypass_path_a: assert property ((mode == IN_BYPASS) |-> value == pin)
        else $error("bypass does not pass pin");
    latch_hold_c: cover property (mode == IN_LATCH ##1 !ck [*3]);

endmodule
`default_nettype wire

//--- hdl/plc_lcc.sv
// logic control cell: four sums in, a D/T/JK register, four outputs
// assumes global controls come from this cell's global cell group
`timescale 1ns/1ps
`default_nettype none
module plc_lcc
    import plc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sum_a,
    input wire logic sum_b,
    input wire logic sum_c,
    input wire logic sum_d,
    input wire logic g_clk,
    input wire logic g_preset,
    input wire logic g_reset,
    input wire logic g_rtype,
    input wire plc_rtype_t rtype,
    input wire logic dyn_type,
    input wire plc_bsel_t bsel,
    input wire plc_csel_t csel,
    input wire plc_dsel_t dsel,
    input wire plc_cksrc_t cksrc,
    input wire logic ck_pol,
    input wire logic async_ctl,
    input wire plc_osel_t osel_pin,
    input wire plc_osel_t osel_bur,
    output logic out_pin,
    output logic out_bur,
    output logic out_oe,
    output logic out_fb
);

    plc_lcc_st_t st_q;
    plc_lcc_st_t st_d;
    plc_rtype_t typ;
    logic ck_lvl;
    logic ck_edge;
    logic pre;
    logic clr;
    logic k;
    logic nxt;

    function automatic logic pick(plc_osel_t s, logic q, logic a, logic b, logic c);
        case (s)
            O_SUMA: return a;
            O_SUMB: return b;
            O_SUMC: return c;
            default: return q;
        endcase
    endfunction

    // register control; reset beats preset when both are asserted
    always_comb
    begin
        case (cksrc)
            CK_SUMC: ck_lvl = sum_c;
            CK_SUMD: ck_lvl = sum_d;
            default: ck_lvl = g_clk;
        endcase
        ck_lvl = ck_lvl ^ ck_pol;
        ck_edge = ck_lvl && !st_q.ck_prev;
        typ = dyn_type ? (g_rtype ? RT_D : RT_T) : rtype;
        k = (bsel == B_K) && sum_b;
        pre = g_preset || (bsel == B_PRESET && sum_b);
        clr = g_reset || (csel == C_RESET && sum_c);
        case (typ)
            RT_D: nxt = sum_a;
            RT_T: nxt = st_q.q ^ sum_a;
            default:
            begin
                // clocked-sr is jk with j and k never both high
                case ({sum_a, k})
                    2'h1: nxt = 1'h0;
                    2'h2: nxt = 1'h1;
                    2'h3: nxt = !st_q.q;
                    default: nxt = st_q.q;
                endcase
            end
        endcase
        st_d = st_q;
        st_d.ck_prev = ck_lvl;
        if (async_ctl && clr)
            st_d.q = 1'h0;
        else if (async_ctl && pre)
            st_d.q = 1'h1;
        else if (ck_edge)
            st_d.q = clr ? 1'h0 : (pre ? 1'h1 : nxt);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '{q: RST_Q, ck_prev: RST_Q};
        else
            st_q <= st_d;
    end

    // pin and buried outputs are independent selections; dsel sends sum d to out_oe or out_fb, never both
    always_comb
    begin
        out_pin = pick(osel_pin, st_q.q, sum_a, sum_b, sum_c);
        out_bur = pick(osel_bur, st_q.q, sum_a, sum_b, sum_c);
        out_oe = (dsel == D_OE) && sum_d;
        out_fb = (dsel == D_FEEDBACK) && sum_d;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    t_count_a: assert property ((ck_edge && typ == RT_T && !clr && !pre) |=> st_q.q == $past(st_q.q ^ sum_a))
        else $error("t register did not toggle");
    dyn_load_a: assert property ((dyn_type && g_rtype && ck_edge && !clr && !pre) |=> st_q.q == $past(sum_a))
        else $error("dynamic d load failed");
    async_clr_a: assert property ((async_ctl && clr) |=> !st_q.q)
        else $error("asynchronous reset not applied");
    preset_b_a: assert property ((bsel == B_PRESET && sum_b && !clr && (async_ctl || ck_edge)) |=> st_q.q)
        else $error("preset from sum b not applied");
    jk_set_a: assert property ((ck_edge && typ == RT_JK && sum_a && !k && !clr && !pre) |=> st_q.q)
        else $error("j input did not set register");
    sync_hold_a: assert property ((!ck_edge && !async_ctl) |=> st_q.q == $past(st_q.q))
        else $error("register changed without clock edge");
    oe_route_a: assert property ((dsel == D_OE) |-> out_oe == sum_d)
        else $error("sum d not routed to output enable");
    toggle_c: cover property (typ == RT_T && ck_edge && sum_a ##[1:20] ck_edge && sum_a);

endmodule
`default_nettype wire

//--- dv/plc_board.sv
// board model on the far side of the io pins
// assumes io_oe_n low means the fabric drives the pin; no pull on the board
`timescale 1ns/1ps
`default_nettype none
module plc_board
    import plc_pkg::*;
(
    input wire logic clk,
    input wire logic [IO_N-1:0] io_out,
    input wire logic [IO_N-1:0] io_oe_n,
    output logic [IO_N-1:0] io_in
);
    logic [IO_N-1:0] last_q = '0;

    // remember the wire level so a released pin can wander
    always_ff @(posedge clk)
    begin
        last_q <= io_in;
    end

    // released pin toggles each cycle: a floating wire must never look stable
    always_comb
    begin
        for (int i = 0; i < IO_N; i++)
        begin
            io_in[i] = io_oe_n[i] ? ~last_q[i] : io_out[i];
        end
    end
endmodule
`default_nettype wire

//--- dv/test_programmable_logic_cell.sv
// directed self-checking scenarios for the logic cell fabric
// assumes plc_board mirrors the io pins; configuration fixed before reset ends
`timescale 1ns/1ps
`default_nettype none
module test_programmable_logic_cell
    import plc_pkg::*;
;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic clock_pin_one = 1'h0;
    logic clock_pin_two = 1'h0;
    logic [IN_N-1:0] in_pin = '0;
    logic [IO_N-1:0] io_in;
    logic [IO_N-1:0] io_out;
    logic [IO_N-1:0] io_oe_n;
    logic [PT_N-1:0][ARR_N-1:0] and_t_cfg;
    logic [PT_N-1:0][ARR_N-1:0] and_c_cfg;
    logic [SUM_N-1:0][PT_N-1:0] or_cfg;
    plc_gck_t gck_sel_cfg [2];
    logic [1:0] gio_pol_cfg = 2'h0;
    plc_rtype_t rtype_cfg [LCC_N];
    logic [LCC_N-1:0] dyn_type_cfg = '0;
    plc_bsel_t bsel_cfg [LCC_N];
    plc_csel_t csel_cfg [LCC_N];
    plc_dsel_t dsel_cfg [LCC_N];
    plc_cksrc_t cksrc_cfg [LCC_N];
    logic [LCC_N-1:0] ck_pol_cfg = '0;
    logic [LCC_N-1:0] async_cfg = 12'h004;
    plc_osel_t osel_pin_cfg [LCC_N];
    plc_osel_t osel_bur_cfg [LCC_N];
    plc_inmode_t inc_mode_cfg [IN_N];
    plc_inmode_t ioc_mode_cfg [IO_N];
    logic [3:0] io_src_cfg [IO_N];
    logic [IO_N-1:0] io_pol_cfg = 12'h002;
    plc_oe_t io_oe_cfg [IO_N];
    int n_mismatch = 0;
    int total_checks = 0;

    plc_fabric dut (.clk, .reset_n, .clock_pin_one, .clock_pin_two, .in_pin, .io_in, .io_out, .io_oe_n,
        .and_t_cfg, .and_c_cfg, .or_cfg, .gck_sel_cfg, .gio_pol_cfg, .rtype_cfg, .dyn_type_cfg, .bsel_cfg,
        .csel_cfg, .dsel_cfg, .cksrc_cfg, .ck_pol_cfg, .async_cfg, .osel_pin_cfg, .osel_bur_cfg,
        .inc_mode_cfg, .ioc_mode_cfg, .io_src_cfg, .io_pol_cfg, .io_oe_cfg);
    plc_board board (.clk, .io_out, .io_oe_n, .io_in);

    // 50 MHz clock
    always #10 clk = ~clk;

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic check(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    // inputs move 2 ns after the edge so no race with the sampling edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // clock pin held two cycles each level; one cycle per level would still be seen as an edge
    task automatic pulse();
        clock_pin_one = 1'h1;
        step(2);
        clock_pin_one = 1'h0;
        step(2);
    endtask

    // product term p takes array input a; all terms start as x and not x
    task automatic lit(input int p, input int a, input bit inv);
        and_t_cfg[p][0] = 1'h0;
        and_c_cfg[p][0] = 1'h0;
        if (inv)
            and_c_cfg[p][a] = 1'h1;
        else
            and_t_cfg[p][a] = 1'h1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    // cell 2 toggles per clock pin pulse, then global reset clears it off-clock
    task automatic t_count();
        for (int k = 1; k <= 3; k++)
        begin
            pulse();
            check("t count", k[0], io_out[2]);
        end
        in_pin[6] = 1'h1;
        step(3);
        check("global reset", 1'h0, io_out[2]);
        in_pin[6] = 1'h0;
        step(1);
        $display("test t_count done");
    endtask

    // d capture appears on the pin exactly two cycles after the clock edge
    task automatic d_walk();
        in_pin[0] = 1'h1;
        step(3);
        check("d before edge", 1'h0, io_out[0]);
        clock_pin_one = 1'h1;
        step(1);
        check("d early", 1'h0, io_out[0]);
        step(1);
        check("d captured", 1'h1, io_out[0]);
        clock_pin_one = 1'h0;
        in_pin[0] = 1'h0;
        step(3);
        check("d held", 1'h1, io_out[0]);
        check("pin readback", 1'h1, io_out[5]);
        check("oe driving", 1'h0, io_oe_n[0]);
        check("oe off", 1'h1, io_oe_n[6]);
        check("reserved term", 1'h0, io_out[6]);
        $display("test d_walk done");
    endtask

    // term 0 shared by cells 0, 1, 7, 8 and 9; cell 1 output is inverted at the pin
    task automatic comb_share();
        for (int v = 0; v < 4; v++)
        begin
            in_pin[1:0] = v[1:0];
            step(1);
            check("shared sum", ~(v[0] | ~v[1]), io_out[1]);
        end
        $display("test comb_share done");
    endtask

    // input 3 registered, input 4 latched, both on the group A clock
    task automatic in_store();
        in_pin[4:3] = 2'h3;
        step(4);
        check("reg before edge", 1'h0, io_out[3]);
        check("latch closed", 1'h0, io_out[4]);
        clock_pin_one = 1'h1;
        step(4);
        check("reg captured", 1'h1, io_out[3]);
        check("latch open", 1'h1, io_out[4]);
        in_pin[4:3] = 2'h0;
        step(4);
        check("reg held", 1'h1, io_out[3]);
        check("latch follows", 1'h0, io_out[4]);
        clock_pin_one = 1'h0;
        in_pin[4:3] = 2'h3;
        step(4);
        check("latch held", 1'h0, io_out[4]);
        $display("test in_store done");
    endtask

    // group b on clock pin two: cell 8 jk, cell 9 dynamic type, cell 10 preset from sum b
    task automatic t_group_b();
        logic [2:0] stim [3] = '{3'h6, 3'h3, 3'h1};
        logic [2:0] want [3] = '{3'h0, 3'h3, 3'h5};
        for (int s = 0; s < 3; s++)
        begin
            in_pin[2:0] = stim[s];
            clock_pin_two = 1'h1;
            step(2);
            clock_pin_two = 1'h0;
            step(2);
            check("jk set", want[s][0], io_out[8]);
            check("dynamic type", want[s][1], io_out[9]);
            check("sum b preset", want[s][2], io_out[10]);
            check("oe from sum d", ~stim[s][0], io_oe_n[7]);
        end
        in_pin[2:0] = 3'h0;
        step(1);
        $display("test t_group_b done");
    endtask

    // a stuck run counts as a mismatch
    initial
    begin
        #200000;
        n_mismatch++;
        finish_test();
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial
    begin
        and_t_cfg = '0;
        and_c_cfg = '0;
        or_cfg = '0;
        for (int p = 0; p < PT_N; p++)
        begin
            and_t_cfg[p][0] = 1'h1;
            and_c_cfg[p][0] = 1'h1;
        end
        lit(0, ARR_INC, 1'b0);
        lit(1, ARR_INC + 1, 1'b1);
        and_t_cfg[2][0] = 1'h0;
        and_c_cfg[2][0] = 1'h0;
        lit(3, ARR_INC + 3, 1'b0);
        lit(4, ARR_INC + 6, 1'b0);
        lit(5, ARR_INC + 4, 1'b0);
        lit(6, ARR_IOC, 1'b0);
        or_cfg[0][0] = 1'h1;
        or_cfg[4][0] = 1'h1;
        or_cfg[4][1] = 1'h1;
        or_cfg[8][2] = 1'h1;
        or_cfg[12][3] = 1'h1;
        or_cfg[16][5] = 1'h1;
        or_cfg[20][6] = 1'h1;
        or_cfg[GSUM_RST][4] = 1'h1;
        lit(61, ARR_INC + 2, 1'b0);
        and_t_cfg[62][0] = 1'h0;
        and_c_cfg[62][0] = 1'h0;
        or_cfg[24][62] = 1'h1;
        or_cfg[31][0] = 1'h1;
        or_cfg[32][0] = 1'h1;
        or_cfg[36][0] = 1'h1;
        or_cfg[41][1] = 1'h1;
        gck_sel_cfg[0] = GK_PIN1;
        gck_sel_cfg[1] = GK_PIN2;
        for (int i = 0; i < LCC_N; i++)
        begin
            rtype_cfg[i] = RT_D;
            bsel_cfg[i] = B_COMB;
            csel_cfg[i] = C_COMB;
            dsel_cfg[i] = D_FEEDBACK;
            cksrc_cfg[i] = CK_GLOBAL;
            osel_pin_cfg[i] = O_SUMA;
            osel_bur_cfg[i] = O_Q;
            inc_mode_cfg[i] = IN_BYPASS;
            ioc_mode_cfg[i] = IN_BYPASS;
            io_src_cfg[i] = 4'(i);
            io_oe_cfg[i] = OE_ON;
        end
        osel_pin_cfg[0] = O_Q;
        osel_pin_cfg[2] = O_Q;
        rtype_cfg[2] = RT_T;
        inc_mode_cfg[3] = IN_REG;
        inc_mode_cfg[4] = IN_LATCH;
        io_oe_cfg[6] = OE_OFF;
        dsel_cfg[7] = D_OE;
        io_oe_cfg[7] = OE_SUMD;
        rtype_cfg[8] = RT_JK;
        dyn_type_cfg[9] = 1'h1;
        bsel_cfg[10] = B_PRESET;
        osel_pin_cfg[8] = O_Q;
        osel_pin_cfg[9] = O_Q;
        osel_pin_cfg[10] = O_Q;
        step(1);
        check("oe during reset", 1'h1, &io_oe_n);
        check("out during reset", 1'h0, |io_out);
        step(1);
        reset_n = 1'h1;
        step(3);
        t_count();
        d_walk();
        comb_share();
        in_store();
        t_group_b();
        finish_test();
    end
endmodule
`default_nettype wire
